/* File: design/pcs_nibble_codec.v */
// Nibble to code-group coding sublayer with alignment, carrier sense and collision.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"


module pcs_nibble_codec (
   input wire sys_clk,
   input wire reset,
   input wire [3:0] txd,
   input wire txEn,
   input wire txEr,
   input wire txValid,
   output wire txReady,
   output wire txCodeBit,
   input wire rxCodeBit,
   input wire linkStatus,
   output wire [3:0] rxd,
   output wire rxDv,
   output wire rxEr,
   output wire rxStrobe,
   output wire crs,
   output wire col
);

   // ***************************************************************
   // State codes.
   // ***************************************************************
   localparam [1:0] TX_IDLE = 2'h0; // Sending idle fill.
   localparam [1:0] TX_SSDK = 2'h1; // Second half of start delimiter.
   localparam [1:0] TX_DATA = 2'h2; // Sending stream data.
   localparam [1:0] TX_ESDR = 2'h3; // Second half of end delimiter.
   localparam [1:0] RX_HUNT = 2'h0; // Searching for the start delimiter.
   localparam [1:0] RX_DATA = 2'h1; // Aligned, decoding groups.
   localparam [1:0] RX_WAITR = 2'h2; // T seen, expecting R.

   // ***************************************************************
   // Coding functions.
   // ***************************************************************

   // Maps a nibble to its data code-group.
   function [4:0] encNibble;
      input [3:0] nib;
      begin
         case (nib)
            4'h0: encNibble = `PCS_CG_D0;
            4'h1: encNibble = `PCS_CG_D1;
            4'h2: encNibble = `PCS_CG_D2;
            4'h3: encNibble = `PCS_CG_D3;
            4'h4: encNibble = `PCS_CG_D4;
            4'h5: encNibble = `PCS_CG_D5;
            4'h6: encNibble = `PCS_CG_D6;
            4'h7: encNibble = `PCS_CG_D7;
            4'h8: encNibble = `PCS_CG_D8;
            4'h9: encNibble = `PCS_CG_D9;
            4'hA: encNibble = `PCS_CG_DA;
            4'hB: encNibble = `PCS_CG_DB;
            4'hC: encNibble = `PCS_CG_DC;
            4'hD: encNibble = `PCS_CG_DD;
            4'hE: encNibble = `PCS_CG_DE;
            default: encNibble = `PCS_CG_DF;
         endcase
      end
   endfunction

   // Returns a data flag above the decoded nibble; non-data groups give zero.
   function [4:0] decGroup;
      input [4:0] grp;
      begin
         case (grp)
            `PCS_CG_D0: decGroup = 5'h10;
            `PCS_CG_D1: decGroup = 5'h11;
            `PCS_CG_D2: decGroup = 5'h12;
            `PCS_CG_D3: decGroup = 5'h13;
            `PCS_CG_D4: decGroup = 5'h14;
            `PCS_CG_D5: decGroup = 5'h15;
            `PCS_CG_D6: decGroup = 5'h16;
            `PCS_CG_D7: decGroup = 5'h17;
            `PCS_CG_D8: decGroup = 5'h18;
            `PCS_CG_D9: decGroup = 5'h19;
            `PCS_CG_DA: decGroup = 5'h1A;
            `PCS_CG_DB: decGroup = 5'h1B;
            `PCS_CG_DC: decGroup = 5'h1C;
            `PCS_CG_DD: decGroup = 5'h1D;
            `PCS_CG_DE: decGroup = 5'h1E;
            `PCS_CG_DF: decGroup = 5'h1F;
            default: decGroup = 5'h00;
         endcase
      end
   endfunction

   // ***************************************************************
   // Transmit buffer.
   // ***************************************************************
   wire bufValid; // A client nibble waits.
   wire [5:0] bufData; // Waiting word: enable, error, nibble.
   wire bufPop; // The serializer takes the waiting word.

   // Client nibbles wait here; txReady stalls the client when both slots fill.
   pcs_skid_buf txBuf (
      .sys_clk(sys_clk),
      .reset(reset),
      .inValid(txValid),
      .inReady(txReady),
      .inData({txEn, txEr, txd}),
      .outValid(bufValid),
      .outReady(bufPop),
      .outData(bufData)
   );

   // ***************************************************************
   // Transmit process.
   // ***************************************************************
   reg [1:0] txState_r; // Transmit state.
   reg [1:0] txState_nxt; // Next transmit state.
   reg [4:0] txGroup_nxt; // Group loaded at the next boundary.
   reg txPop; // Word is consumed at the boundary.
   reg [4:0] txSh_r; // Group being shifted out.
   reg [2:0] txBitCnt_r; // Bit position within the group.
   reg txActive_r; // Internal transmitting flag.
   wire txLoad; // Last bit of the group is on the line.

   assign txLoad = (txBitCnt_r == `PCS_LAST_BIT);
   assign bufPop = txLoad & txPop;

   // Chooses the next group from the waiting word; a missing word ends a stream.
   always @* begin
      txState_nxt = txState_r;
      txGroup_nxt = `PCS_CG_IDLE;
      txPop = bufValid;
      if (!linkStatus) begin
         // Link lost: fall back to idle and flush the client words.
         txState_nxt = TX_IDLE;
      end else begin
         case (txState_r)
            TX_IDLE: begin
               if (bufValid && bufData[5]) begin
                  // First preamble nibble is replaced by J.
                  txGroup_nxt = `PCS_CG_J;
                  txState_nxt = TX_SSDK;
               end
            end
            TX_SSDK: begin
               // Second preamble nibble is replaced by K.
               txGroup_nxt = `PCS_CG_K;
               txState_nxt = TX_DATA;
            end
            TX_DATA: begin
               if (bufValid && bufData[5]) begin
                  if (bufData[4]) begin
                     txGroup_nxt = `PCS_CG_H;
                  end else begin
                     txGroup_nxt = encNibble(bufData[3:0]);
                  end
               end else begin
                  // Enable dropped or nothing waits: close the stream.
                  txGroup_nxt = `PCS_CG_T;
                  txState_nxt = TX_ESDR;
               end
            end
            TX_ESDR: begin
               txGroup_nxt = `PCS_CG_R;
               txState_nxt = TX_IDLE;
               txPop = 1'b0;
            end
            default: begin
               txState_nxt = TX_IDLE;
            end
         endcase
      end
   end

   // Transmit bits: one code-bit per clock, most significant bit first.
   always @(posedge sys_clk) begin
      if (reset) begin
         txState_r <= TX_IDLE;
         txSh_r <= `PCS_CG_IDLE;
         txBitCnt_r <= 3'h0;
         txActive_r <= 1'b0;
      end else if (txLoad) begin
         // Groups follow one another with no gap.
         txState_r <= txState_nxt;
         txSh_r <= txGroup_nxt;
         txBitCnt_r <= 3'h0;
         txActive_r <= (txGroup_nxt != `PCS_CG_IDLE);
      end else begin
         txSh_r <= {txSh_r[3:0], 1'b1};
         txBitCnt_r <= txBitCnt_r + 3'h1;
         if (!linkStatus) begin
            txActive_r <= 1'b0;
         end
      end
   end

   assign txCodeBit = txSh_r[4];

   // ***************************************************************
   // Receive process.
   // ***************************************************************
   reg [9:0] rxSh_r; // Last ten received code-bits.
   reg [1:0] rxState_r; // Receive state.
   reg [2:0] rxBitCnt_r; // Bit position within the aligned group.
   reg rxActive_r; // Internal receiving flag.
   reg pre2_r; // Second restored preamble nibble is due.
   reg [3:0] rxd_r; // Received nibble.
   reg rxDv_r; // Received data valid.
   reg rxEr_r; // Received error.
   reg rxStrobe_r; // New nibble on the outputs.
   wire [9:0] rxShNext; // Shift register including this clock's bit.
   wire [4:0] rxGroup; // Group just completed on the aligned boundary.
   wire [4:0] rxDec; // Decoded group.
   wire rxBoundary; // A whole aligned group has arrived.

   assign rxShNext = {rxSh_r[8:0], rxCodeBit};
   assign rxGroup = rxShNext[4:0];
   assign rxDec = decGroup(rxGroup);
   assign rxBoundary = (rxBitCnt_r == `PCS_LAST_BIT);

   // Receive bits: every clock shifts in one code-bit.
   always @(posedge sys_clk) begin
      if (reset) begin
         rxSh_r <= 10'h000;
      end else begin
         rxSh_r <= rxShNext;
      end
   end

   // Alignment, decoding and stream framing.
   always @(posedge sys_clk) begin
      if (reset) begin
         rxState_r <= RX_HUNT;
         rxBitCnt_r <= 3'h0;
         rxActive_r <= 1'b0;
         pre2_r <= 1'b0;
         rxd_r <= 4'h0;
         rxDv_r <= 1'b0;
         rxEr_r <= 1'b0;
         rxStrobe_r <= 1'b0;
      end else if (!linkStatus) begin
         // Link lost: abandon any stream and hunt again.
         rxState_r <= RX_HUNT;
         rxActive_r <= 1'b0;
         pre2_r <= 1'b0;
         rxDv_r <= 1'b0;
         rxEr_r <= 1'b0;
         rxStrobe_r <= 1'b0;
      end else begin
         rxStrobe_r <= 1'b0;
         rxBitCnt_r <= rxBoundary ? 3'h0 : rxBitCnt_r + 3'h1;
         case (rxState_r)
            RX_HUNT: begin
               rxDv_r <= 1'b0;
               rxEr_r <= 1'b0;
               if (rxShNext == `PCS_SSD_PAIR) begin
                  // J K fixes the boundary and restores the first preamble nibble.
                  rxState_r <= RX_DATA;
                  rxBitCnt_r <= 3'h0;
                  rxActive_r <= 1'b1;
                  rxd_r <= `PCS_PREAMBLE_NIB;
                  rxDv_r <= 1'b1;
                  rxStrobe_r <= 1'b1;
                  pre2_r <= 1'b1;
               end
            end
            RX_DATA: begin
               if (pre2_r) begin
                  // Second restored preamble nibble.
                  rxStrobe_r <= 1'b1;
                  pre2_r <= 1'b0;
               end
               if (rxBoundary) begin
                  if (rxDec[4]) begin
                     // Data is decoded only inside an aligned stream.
                     rxd_r <= rxDec[3:0];
                     rxEr_r <= 1'b0;
                     rxStrobe_r <= 1'b1;
                  end else if (rxGroup == `PCS_CG_T) begin
                     rxState_r <= RX_WAITR;
                  end else if (rxGroup == `PCS_CG_IDLE) begin
                     // Idle inside a stream ends it without a delimiter.
                     rxState_r <= RX_HUNT;
                     rxActive_r <= 1'b0;
                     rxDv_r <= 1'b0;
                  end else begin
                     // H, stray control or invalid group marks an error nibble.
                     rxd_r <= 4'h0;
                     rxEr_r <= 1'b1;
                     rxStrobe_r <= 1'b1;
                  end
               end
            end
            RX_WAITR: begin
               if (rxBoundary) begin
                  rxState_r <= RX_HUNT;
                  rxActive_r <= 1'b0;
                  if (rxGroup == `PCS_CG_R) begin
                     rxDv_r <= 1'b0;
                  end else begin
                     // Broken end delimiter: flag one error nibble, then drop valid.
                     rxd_r <= 4'h0;
                     rxEr_r <= 1'b1;
                     rxStrobe_r <= 1'b1;
                  end
               end
            end
            default: begin
               rxState_r <= RX_HUNT;
               rxActive_r <= 1'b0;
            end
         endcase
      end
   end

   assign rxd = rxd_r;
   assign rxDv = rxDv_r;
   assign rxEr = rxEr_r;
   assign rxStrobe = rxStrobe_r;

   // ***************************************************************
   // Carrier sense and collision.
   // ***************************************************************
   reg crs_r; // Carrier sense output.
   reg col_r; // Collision output.

   // Both indications are registered one clock after the flags.
   always @(posedge sys_clk) begin
      if (reset) begin
         crs_r <= 1'b0;
         col_r <= 1'b0;
      end else begin
         crs_r <= txActive_r | rxActive_r;
         col_r <= txActive_r & rxActive_r;
      end
   end

   assign crs = crs_r;
   assign col = col_r;

endmodule // pcs_nibble_codec

`default_nettype wire

/* File: design/pcs_regs.vh */
// Code-group values, delimiters and timing counts of the nibble codec.
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// ***************************************************************
// Control code-groups.
// ***************************************************************
`define PCS_CG_IDLE 5'h1F
`define PCS_CG_J 5'h18
`define PCS_CG_K 5'h11
`define PCS_CG_T 5'h0D
`define PCS_CG_R 5'h07
`define PCS_CG_H 5'h04

// ***************************************************************
// Data code-groups, one per nibble value.
// ***************************************************************
`define PCS_CG_D0 5'h1E
`define PCS_CG_D1 5'h09
`define PCS_CG_D2 5'h14
`define PCS_CG_D3 5'h15
`define PCS_CG_D4 5'h0A
`define PCS_CG_D5 5'h0B
`define PCS_CG_D6 5'h0E
`define PCS_CG_D7 5'h0F
`define PCS_CG_D8 5'h12
`define PCS_CG_D9 5'h13
`define PCS_CG_DA 5'h16
`define PCS_CG_DB 5'h17
`define PCS_CG_DC 5'h1A
`define PCS_CG_DD 5'h1B
`define PCS_CG_DE 5'h1C
`define PCS_CG_DF 5'h1D

// ***************************************************************
// Stream framing and timing counts.
// ***************************************************************
`define PCS_SSD_PAIR 10'h311
`define PCS_PREAMBLE_NIB 4'h5
`define PCS_LAST_BIT 3'h4
`define PCS_TXBUF_WIDTH 6

`endif

/* File: design/pcs_skid_buf.v */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module pcs_skid_buf (
   input wire sys_clk,
   input wire reset,
   input wire inValid,
   output wire inReady,
   input wire [5:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [5:0] outData
);

   // ***************************************************************
   // Storage and pointers.
   // ***************************************************************
   reg [5:0] mem_r [0:1]; // The two stored words.
   reg wrPtr_r; // Slot written next.
   reg rdPtr_r; // Slot read next.
   reg [1:0] count_r; // Number of words held.

   wire doPush; // A word enters this cycle.
   wire doPop; // A word leaves this cycle.

   // Full and empty are honest: ready drops only when both slots hold a word.
   assign inReady = (count_r != 2'h2);
   assign outValid = (count_r != 2'h0);
   assign outData = mem_r[rdPtr_r];
   assign doPush = inValid & inReady;
   assign doPop = outValid & outReady;

   // Pointers and the count move on push and pop.
   always @(posedge sys_clk) begin
      if (reset) begin
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (doPush) begin
            wrPtr_r <= ~wrPtr_r;
         end
         if (doPop) begin
            rdPtr_r <= ~rdPtr_r;
         end
         if (doPush && !doPop) begin
            count_r <= count_r + 2'h1;
         end else if (doPop && !doPush) begin
            count_r <= count_r - 2'h1;
         end
      end
   end

   // The slot under the write pointer takes the incoming word.
   always @(posedge sys_clk) begin
      if (doPush) begin
         mem_r[wrPtr_r] <= inData;
      end
   end

endmodule // pcs_skid_buf

`default_nettype wire

/* File: dv/pcs_4b5b_nibble_codec_tb.sv */
// Self-checking bench for the nibble codec.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.vh"

module pcs_4b5b_nibble_codec_tb;
   // Data code-groups indexed by nibble.
   localparam logic [4:0] DCG [16] = '{`PCS_CG_D0, `PCS_CG_D1, `PCS_CG_D2, `PCS_CG_D3, `PCS_CG_D4, `PCS_CG_D5,
      `PCS_CG_D6, `PCS_CG_D7, `PCS_CG_D8, `PCS_CG_D9, `PCS_CG_DA, `PCS_CG_DB, `PCS_CG_DC, `PCS_CG_DD,
      `PCS_CG_DE, `PCS_CG_DF};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic txEn = 1'b0;
   logic txEr = 1'b0;
   logic txValid = 1'b0;
   logic linkStatus = 1'b1;
   logic [3:0] txd = 4'h0;
   wire logic txReady, txCodeBit, rxCodeBit, rxDv, rxEr, rxStrobe, crs, col;
   wire logic [3:0] rxd;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [4:0] rxQ [$]; // Received {error, nibble} per strobe.
   logic sawCol = 1'b0;
   logic sawFull = 1'b0;

   pcs_nibble_codec u_pcs_nibble_codec (.sys_clk(clk), .reset(rst), .txd(txd), .txEn(txEn), .txEr(txEr),
      .txValid(txValid), .txReady(txReady), .txCodeBit(txCodeBit), .rxCodeBit(rxCodeBit),
      .linkStatus(linkStatus), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .rxStrobe(rxStrobe), .crs(crs), .col(col));
   pcs_line_model u_pcs_line_model (.sys_clk(clk), .txCodeBit(txCodeBit), .rxCodeBit(rxCodeBit));

   initial forever #25 clk = ~clk;

   // Collects strobes and flags, and cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rxStrobe === 1'b1) rxQ.push_back({rxEr, rxd});
      if (col === 1'b1) sawCol <= 1'b1;
      if (txReady === 1'b0) sawFull <= 1'b1;
      if (cycles == 2000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Compares and empties the strobe record.
   task automatic expectRx(input logic [4:0] exp [$]);
      check("rx count", 10'(rxQ.size()), 10'(exp.size()));
      foreach (exp[i]) if (i < rxQ.size()) check("rx nibble", 10'(rxQ[i]), 10'(exp[i]));
      rxQ.delete();
   endtask

   task automatic rxSend(input logic [4:0] g [$]);
      foreach (g[i]) u_pcs_line_model.sendGroup(g[i]);
   endtask

   // Offers one word and holds it until taken; called just after an edge.
   task automatic sendWord(input logic [3:0] d, input logic en, input logic er);
      txd <= d;
      txEn <= en;
      txEr <= er;
      txValid <= 1'b1;
      @(posedge clk);
      while (txReady !== 1'b1) @(posedge clk);
   endtask

   task automatic testReset();
      check("txReady", 10'(txReady), 10'h1);
      check("crs", 10'(crs), 10'h0);
      repeat (10) @(posedge clk);
      check("idle fill", u_pcs_line_model.txHist, 10'h3FF);
   endtask

   task automatic testRxFrame();
      logic [4:0] g [$];
      logic [4:0] e [$];
      g = '{`PCS_CG_J, `PCS_CG_K};
      e = '{5'h05, 5'h05};
      for (int i = 0; i < 16; i++) begin
         g.push_back(DCG[i]);
         e.push_back(5'(i));
      end
      g = {g, `PCS_CG_T, `PCS_CG_R, `PCS_CG_IDLE};
      rxSend(g);
      check("rxDv after end", 10'(rxDv), 10'h0);
      expectRx(e);
   endtask

   // Errors in a stream, a bad end, groups outside a stream, idle end.
   task automatic testRxErrors();
      rxSend('{`PCS_CG_J, `PCS_CG_K, `PCS_CG_H, `PCS_CG_D3, 5'h00, `PCS_CG_T, `PCS_CG_D1, `PCS_CG_IDLE,
         `PCS_CG_D7, `PCS_CG_D7, `PCS_CG_J, `PCS_CG_K, `PCS_CG_D2, `PCS_CG_IDLE});
      if (rxQ.size() > 5) begin
         check("bad end error", 10'(rxQ[5][4]), 10'h1);
         rxQ[5] = 5'h10;
      end
      check("rxEr after idle end", 10'(rxEr), 10'h0);
      expectRx('{5'h05, 5'h05, 5'h10, 5'h03, 5'h10, 5'h10, 5'h05, 5'h05, 5'h02});
   endtask

   // Transmit frame with an error word, while a frame is received.
   task automatic testTxFrame();
      logic [4:0] r [$];
      int n;
      fork
         begin
            sendWord(4'h5, 1'b1, 1'b0);
            sendWord(4'h5, 1'b1, 1'b0);
            for (int i = 0; i < 16; i++) sendWord(4'(i), 1'b1, 1'b0);
            sendWord(4'h0, 1'b1, 1'b1);
            txValid <= 1'b0;
         end
         begin
            n = 0;
            while (u_pcs_line_model.txHist !== {`PCS_CG_J, `PCS_CG_K} && n < 200) begin
               @(posedge clk);
               n++;
            end
            for (int i = 0; i < 20; i++) begin
               repeat (5) @(posedge clk);
               r.push_back(u_pcs_line_model.txHist[4:0]);
            end
         end
         begin
            repeat (30) @(posedge clk);
            rxSend('{`PCS_CG_J, `PCS_CG_K, `PCS_CG_D9, `PCS_CG_D6, `PCS_CG_T, `PCS_CG_R, `PCS_CG_IDLE});
         end
      join
      check("group count", 10'(r.size()), 10'h014);
      for (int i = 0; i < 16; i++) check("tx data", 10'(r[i]), 10'(DCG[i]));
      check("tx error", 10'(r[16]), 10'(`PCS_CG_H));
      check("tx end", {r[17], r[18]}, {`PCS_CG_T, `PCS_CG_R});
      check("tx idle", 10'(r[19]), 10'(`PCS_CG_IDLE));
      check("collision", 10'(sawCol), 10'h1);
      check("buffer full", 10'(sawFull), 10'h1);
      expectRx('{5'h05, 5'h05, 5'h09, 5'h06});
   endtask

   // Link loss in mid-stream, with a word offered while down.
   task automatic testLinkDown();
      fork
         rxSend('{`PCS_CG_J, `PCS_CG_K, `PCS_CG_D1, `PCS_CG_D2, `PCS_CG_D3, `PCS_CG_D4, `PCS_CG_IDLE});
         begin
            repeat (17) @(posedge clk);
            linkStatus <= 1'b0;
            repeat (3) @(posedge clk);
            check("rxDv link down", 10'(rxDv), 10'h0);
            check("crs link down", 10'(crs), 10'h0);
            sendWord(4'h5, 1'b1, 1'b0);
            txValid <= 1'b0;
            repeat (12) @(posedge clk);
            check("tx link down", u_pcs_line_model.txHist, 10'h3FF);
            linkStatus <= 1'b1;
         end
      join
      expectRx('{5'h05, 5'h05, 5'h01});
   endtask

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      testReset();
      testRxFrame();
      testRxErrors();
      testTxFrame();
      testLinkDown();
      end_of_test();
   end
endmodule // pcs_4b5b_nibble_codec_tb

`default_nettype wire

/* File: dv/pcs_line_model.sv */
// Line-side model: sends code-groups and records transmitted code-bits.
`timescale 1ns/1ps
`default_nettype none

module pcs_line_model (
   input wire logic sys_clk,
   input wire logic txCodeBit,
   output logic rxCodeBit
);
   // Last ten transmitted code-bits, newest in bit 0.
   logic [9:0] txHist = 10'h3FF;
   // The line rests at ones, which is the idle fill.
   initial rxCodeBit = 1'b1;
   // Records every transmitted code-bit.
   always @(posedge sys_clk) begin
      txHist <= {txHist[8:0], txCodeBit};
   end
   // Sends one code-group, most significant bit first, one bit a clock.
   task automatic sendGroup(input logic [4:0] g);
      for (int i = 4; i >= 0; i--) begin
         rxCodeBit <= g[i];
         @(posedge sys_clk);
      end
   endtask
endmodule // pcs_line_model

`default_nettype wire

/* File: dv/pcs_nibble_codec_checker.sv */
// Concurrent checks on the ports of the nibble codec.
`timescale 1ns/1ps
`default_nettype none

module pcs_nibble_codec_checker (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] txd,
   input wire logic txEn,
   input wire logic txEr,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic txCodeBit,
   input wire logic rxCodeBit,
   input wire logic linkStatus,
   input wire logic [3:0] rxd,
   input wire logic rxDv,
   input wire logic rxEr,
   input wire logic rxStrobe,
   input wire logic crs,
   input wire logic col
);
   // ***************************************************************
   // Sequences of a received stream start.
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // A new stream shows as the rise of the data valid flag.
   sequence streamStart;
      $rose(rxDv);
   endsequence
   // Two preamble nibbles on adjacent clocks, then a gap of three.
   sequence preamblePair;
      rxStrobe && rxd == 4'h5 ##1 rxStrobe && rxDv && rxd == 4'h5 ##1 !rxStrobe [*3];
   endsequence

   // ***************************************************************
   // Assertions.
   // ***************************************************************
   col_needs_crs_a: assert property (col |-> crs)
      else $error("collision without carrier sense");
   reset_idle_state_a: assert property ($fell(reset) |-> txCodeBit && txReady && !rxDv && !rxStrobe && !crs && !col)
      else $error("outputs not idle after reset");
   link_clears_rx_a: assert property (!linkStatus |=> !rxDv && !rxEr && !rxStrobe)
      else $error("receive outputs live with link down");
   link_drops_crs_a: assert property (!linkStatus [*2] |=> !crs && !col)
      else $error("carrier kept with link down");
   preamble_restored_a: assert property (streamStart |-> preamblePair)
      else $error("preamble not restored at stream start");
   group_spacing_a: assert property (rxStrobe && !$past(rxStrobe) && $past(rxDv) |=> !rxStrobe [*4])
      else $error("nibbles closer than five code-bits");
   error_in_stream_a: assert property (rxEr |-> rxDv)
      else $error("receive error outside a stream");
   tx_start_carrier_a: assert property (!crs && linkStatus && txValid && txReady && txEn |-> ##[1:16] crs)
      else $error("no carrier after frame start");
   // The receiving flag rises with the stream, so carrier follows one clock later.
   rx_start_carrier_a: assert property (streamStart |-> ##1 crs)
      else $error("no carrier after stream start");
endmodule // pcs_nibble_codec_checker

bind pcs_nibble_codec pcs_nibble_codec_checker u_pcs_nibble_codec_checker (.sys_clk(sys_clk), .reset(reset),
   .txd(txd), .txEn(txEn), .txEr(txEr), .txValid(txValid), .txReady(txReady), .txCodeBit(txCodeBit),
   .rxCodeBit(rxCodeBit), .linkStatus(linkStatus), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr),
   .rxStrobe(rxStrobe), .crs(crs), .col(col));

`default_nettype wire
